/* File: shared/ncb_regs.svh */
// register offsets, reset values and field layout for the channel b nco presets
`ifndef NCB_REGS_SVH
`define NCB_REGS_SVH
`define NCB_FREQ_PRESET0_OFS 12'h240
`define NCB_PHASE_PRESET0_OFS 12'h244
`define NCB_FREQ_PRESET1_OFS 12'h248
`define NCB_PHASE_PRESET1_OFS 12'h24c
`define NCB_FREQ_PRESET2_OFS 12'h250
`define NCB_PHASE_PRESET2_OFS 12'h254
`define NCB_FREQ_PRESET3_OFS 12'h258
`define NCB_PHASE_PRESET3_OFS 12'h25c
`define NCB_BASE_OFS 12'h240
`define NCB_FREQ_RESET 32'hc0000000
`define NCB_PHASE_RESET 16'h0000
`define NCB_FREQ_MSB 31
`define NCB_PHASE_MSB 15
`define NCB_PRESETS 4
`endif

/* File: shared/ncb_pkg.sv */
// types for the channel b nco preset bank
package ncb_pkg;
  typedef logic [31:0] ncb_freq_t;
  typedef logic [15:0] ncb_phase_t;
  typedef logic [11:0] ncb_addr_t;
  typedef logic [1:0] ncb_sel_t;
  typedef struct packed {
    ncb_freq_t [3:0] freq;
    ncb_phase_t [3:0] phase;
    logic [31:0] rdata;
    ncb_freq_t nco_freq;
    logic [31:0] nco_phase;
    logic nco_valid;
  } ncb_state_s;
endpackage

/* File: hdl/ncb_preset_bank.sv */
// channel b nco preset registers with selected-preset output
// Behaviour
// - four rw 32-bit frequency words, reset c0000000
// - four rw 16-bit phase words, reset zero
// - interleaved mode ignores channel b presets
// - frequency words at 240, 248, 250, 258
// - phase words at 244, 24c, 254, 25c
// - phase word left justified into 32 bits on nco_phase, zero-extended on readback
// - phase signed or unsigned, same result
`include "ncb_regs.svh"
module ncb_preset_bank (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // register access from the serial port decoder
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire ncb_pkg::ncb_addr_t reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  // mode and preset selection
  input wire logic interleave_mode,
  input wire ncb_pkg::ncb_sel_t preset_sel,
  // to the oscillator
  output ncb_pkg::ncb_freq_t nco_freq,
  output logic [31:0] nco_phase,
  output logic nco_valid
);
  import ncb_pkg::*;

  // ----------------------------------------
  // state and decoded access
  // ----------------------------------------
  ncb_state_s s_q;
  ncb_state_s s_d;
  logic [3:0] freq_we;
  logic [3:0] phase_we;
  logic rd_hit;
  logic rd_miss;

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  // exact match only, so misaligned and foreign offsets fall out
  function automatic logic is_mapped(input ncb_addr_t a);
    case (a)
      `NCB_FREQ_PRESET0_OFS: is_mapped = 1'h1;
      `NCB_PHASE_PRESET0_OFS: is_mapped = 1'h1;
      `NCB_FREQ_PRESET1_OFS: is_mapped = 1'h1;
      `NCB_PHASE_PRESET1_OFS: is_mapped = 1'h1;
      `NCB_FREQ_PRESET2_OFS: is_mapped = 1'h1;
      `NCB_PHASE_PRESET2_OFS: is_mapped = 1'h1;
      `NCB_FREQ_PRESET3_OFS: is_mapped = 1'h1;
      `NCB_PHASE_PRESET3_OFS: is_mapped = 1'h1;
      default: is_mapped = 1'h0;
    endcase
  endfunction

  function automatic logic is_freq(input ncb_addr_t a);
    case (a)
      `NCB_FREQ_PRESET0_OFS: is_freq = 1'h1;
      `NCB_FREQ_PRESET1_OFS: is_freq = 1'h1;
      `NCB_FREQ_PRESET2_OFS: is_freq = 1'h1;
      `NCB_FREQ_PRESET3_OFS: is_freq = 1'h1;
      default: is_freq = 1'h0;
    endcase
  endfunction

  function automatic logic is_phase(input ncb_addr_t a);
    case (a)
      `NCB_PHASE_PRESET0_OFS: is_phase = 1'h1;
      `NCB_PHASE_PRESET1_OFS: is_phase = 1'h1;
      `NCB_PHASE_PRESET2_OFS: is_phase = 1'h1;
      `NCB_PHASE_PRESET3_OFS: is_phase = 1'h1;
      default: is_phase = 1'h0;
    endcase
  endfunction

  function automatic ncb_sel_t preset_of(input ncb_addr_t a);
    case (a)
      `NCB_FREQ_PRESET0_OFS: preset_of = 2'h0;
      `NCB_PHASE_PRESET0_OFS: preset_of = 2'h0;
      `NCB_FREQ_PRESET1_OFS: preset_of = 2'h1;
      `NCB_PHASE_PRESET1_OFS: preset_of = 2'h1;
      `NCB_FREQ_PRESET2_OFS: preset_of = 2'h2;
      `NCB_PHASE_PRESET2_OFS: preset_of = 2'h2;
      `NCB_FREQ_PRESET3_OFS: preset_of = 2'h3;
      `NCB_PHASE_PRESET3_OFS: preset_of = 2'h3;
      default: preset_of = 2'h0;
    endcase
  endfunction

  function automatic logic [3:0] freq_strobes(input logic wr, input ncb_addr_t a);
    freq_strobes = 4'h0;
    case (a)
      `NCB_FREQ_PRESET0_OFS: freq_strobes = {3'h0, wr};
      `NCB_FREQ_PRESET1_OFS: freq_strobes = {2'h0, wr, 1'h0};
      `NCB_FREQ_PRESET2_OFS: freq_strobes = {1'h0, wr, 2'h0};
      `NCB_FREQ_PRESET3_OFS: freq_strobes = {wr, 3'h0};
      default: freq_strobes = 4'h0;
    endcase
  endfunction

  function automatic logic [3:0] phase_strobes(input logic wr, input ncb_addr_t a);
    phase_strobes = 4'h0;
    case (a)
      `NCB_PHASE_PRESET0_OFS: phase_strobes = {3'h0, wr};
      `NCB_PHASE_PRESET1_OFS: phase_strobes = {2'h0, wr, 1'h0};
      `NCB_PHASE_PRESET2_OFS: phase_strobes = {1'h0, wr, 2'h0};
      `NCB_PHASE_PRESET3_OFS: phase_strobes = {wr, 3'h0};
      default: phase_strobes = 4'h0;
    endcase
  endfunction

  // ----------------------------------------
  // field shaping
  // ----------------------------------------
  function automatic ncb_freq_t freq_field(input logic [31:0] w);
    freq_field = w[`NCB_FREQ_MSB:0];
  endfunction

  function automatic ncb_phase_t phase_field(input logic [31:0] w);
    phase_field = w[`NCB_PHASE_MSB:0];
  endfunction

  // unused upper half of a phase word reads back as zero
  function automatic logic [31:0] phase_readback(input ncb_phase_t p);
    phase_readback = {16'h0000, p};
  endfunction

  // raw bit pattern kept, so signed and unsigned readings agree mod one turn
  function automatic logic [31:0] phase_to_acc(input ncb_phase_t p);
    phase_to_acc = {p, 16'h0000};
  endfunction

  function automatic logic [31:0] read_word(input ncb_state_s st, input ncb_addr_t a);
    if (is_phase(a)) begin
      read_word = phase_readback(st.phase[preset_of(a)]);
    end else if (is_freq(a)) begin
      read_word = st.freq[preset_of(a)];
    end else begin
      read_word = 32'h00000000;
    end
  endfunction

  // ----------------------------------------
  // preset selection
  // ----------------------------------------
  function automatic ncb_freq_t select_freq(input ncb_state_s st, input ncb_sel_t sel);
    select_freq = st.freq[sel];
  endfunction

  function automatic logic [31:0] select_phase(input ncb_state_s st, input ncb_sel_t sel);
    select_phase = phase_to_acc(st.phase[sel]);
  endfunction

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  function automatic ncb_state_s reset_state();
    ncb_state_s st;
    for (int i = 0; i < `NCB_PRESETS; i++) begin
      st.freq[i] = `NCB_FREQ_RESET;
      st.phase[i] = `NCB_PHASE_RESET;
    end
    st.rdata = 32'h00000000;
    st.nco_freq = 32'h00000000;
    st.nco_phase = 32'h00000000;
    st.nco_valid = 1'h0;
    reset_state = st;
  endfunction

  // ----------------------------------------
  // access qualification
  // ----------------------------------------
  assign freq_we = freq_strobes(reg_wr, reg_addr);
  assign phase_we = phase_strobes(reg_wr, reg_addr);
  assign rd_hit = reg_rd && is_mapped(reg_addr);
  assign rd_miss = reg_rd && !is_mapped(reg_addr);

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    s_d = s_q;
    // register writes
    for (int i = 0; i < `NCB_PRESETS; i++) begin
      if (freq_we[i]) begin
        s_d.freq[i] = freq_field(reg_wdata);
      end
      if (phase_we[i]) begin
        s_d.phase[i] = phase_field(reg_wdata);
      end
    end
    // registered read data, taken from storage before this edge's write
    if (rd_hit) begin
      s_d.rdata = read_word(s_q, reg_addr);
    end
    if (rd_miss) begin
      s_d.rdata = 32'h00000000;
    end
    // selected preset towards the oscillator
    s_d.nco_freq = select_freq(s_q, preset_sel);
    s_d.nco_phase = select_phase(s_q, preset_sel);
    s_d.nco_valid = 1'h1;
    // interleaved mode, channel b settings disregarded
    if (interleave_mode) begin
      s_d.nco_freq = 32'h00000000;
      s_d.nco_phase = 32'h00000000;
      s_d.nco_valid = 1'h0;
    end
    // synchronous reset
    if (reset) begin
      s_d = reset_state();
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    s_q <= s_d;
  end

  // ----------------------------------------
  // outputs, straight from the state register
  // ----------------------------------------
  assign reg_rdata = s_q.rdata;
  assign nco_freq = s_q.nco_freq;
  assign nco_phase = s_q.nco_phase;
  assign nco_valid = s_q.nco_valid;
endmodule // ncb_preset_bank

/* File: dv/ncb_preset_bank_properties.sv */
// checker for the channel b nco preset bank
module ncb_chk (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // register access
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire ncb_pkg::ncb_addr_t reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  // mode and preset selection
  input wire logic interleave_mode,
  input wire ncb_pkg::ncb_sel_t preset_sel,
  // oscillator side
  input wire ncb_pkg::ncb_freq_t nco_freq,
  input wire logic [31:0] nco_phase,
  input wire logic nco_valid
);
  timeunit 1ns;
  timeprecision 1ns;
  import ncb_pkg::*;
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (reset);
  wire sel0_live = !interleave_mode && preset_sel == 2'h0;
  chk_mute_out: assert property (interleave_mode |=>
    !nco_valid && !nco_freq && !nco_phase) else $error("interleaved outputs not muted");
  chk_valid_on: assert property (!reset && !interleave_mode |=> nco_valid)
    else $error("nco valid low outside interleave");
  chk_phase_pos: assert property (nco_phase[15:0] == 16'h0000)
    else $error("phase low half not zero");
  chk_rd_hold: assert property (!reset && !reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  chk_unmapped_read: assert property (reg_rd && reg_addr < 12'h240 |=> !reg_rdata)
    else $error("unmapped read not zero");
  chk_phase_rd: assert property (reg_rd && reg_addr[2] |=> !reg_rdata[31:16])
    else $error("phase read upper half not zero");
  chk_freq_nco: assert property (reg_wr && reg_addr == 12'h240 && sel0_live
    ##1 sel0_live |=> nco_freq == $past(reg_wdata, 2)) else $error("written freq not on nco");
  chk_phase_nco: assert property (reg_wr && reg_addr == 12'h244 && sel0_live
    ##1 sel0_live |=> nco_phase == $past(reg_wdata, 2) << 16) else $error("phase not on nco");
endmodule // ncb_chk
bind ncb_preset_bank ncb_chk chk (
  .core_clk(core_clk),
  .reset(reset),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata),
  .interleave_mode(interleave_mode),
  .preset_sel(preset_sel),
  .nco_freq(nco_freq),
  .nco_phase(nco_phase),
  .nco_valid(nco_valid)
);

/* File: dv/tb_ncb_preset_bank.sv */
// bench for the channel b nco preset bank
module tb_ncb_preset_bank;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 0, reset = 1, reg_wr = 0, reg_rd = 0, interleave_mode = 0, nco_valid;
  logic [1:0] preset_sel = '0;
  logic [11:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0, reg_rdata, nco_phase, nco_freq, d;
  int err_count = 0, checked = 0;
  ncb_preset_bank uut (
    .core_clk(core_clk),
    .reset(reset),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .interleave_mode(interleave_mode),
    .preset_sel(preset_sel),
    .nco_freq(nco_freq),
    .nco_phase(nco_phase),
    .nco_valid(nco_valid)
  );
  task automatic cmp(input string n, input logic [31:0] e, g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] x);
    {reg_wr, reg_rd, reg_addr, reg_wdata} <= {w, !w, a, x};
    @(posedge core_clk);
    {reg_wr, reg_rd} <= 2'h0;
    @(posedge core_clk);
  endtask
  task automatic test_done;
    $display("errors %0d checks %0d", err_count, checked);
    if (err_count == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial forever #10 core_clk = ~core_clk;
  initial begin
    #10000;
    err_count++;
    test_done;
  end
  initial begin
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    for (int i = 0; i < 8; i++) begin
      d = 32'hb5a78f10 + i;
      acc(0, 12'h240 + 12'(i * 4), d);
      cmp("reset", i[0] ? 32'h0 : 32'hc0000000, reg_rdata);
      acc(1, 12'h240 + 12'(i * 4), d);
      acc(0, 12'h240 + 12'(i * 4), d);
      cmp("readback", i[0] ? d & 32'hffff : d, reg_rdata);
    end
    for (int s = 0; s < 4; s++) begin
      preset_sel <= 2'(s);
      repeat (2) @(posedge core_clk);
      cmp("freq", 32'hb5a78f10 + 2 * s, nco_freq);
      cmp("valid", 32'h1, 32'(nco_valid));
      cmp("phase", (32'hb5a78f11 + 2 * s) << 16, nco_phase);
    end
    interleave_mode <= 1'b1;
    repeat (2) @(posedge core_clk);
    cmp("mute", 32'h0, nco_freq | nco_phase | 32'(nco_valid));
    acc(1, 12'h23c, 32'h1);
    acc(0, 12'h23c, 32'h0);
    cmp("unmapped", 32'h0, reg_rdata);
    test_done;
  end
endmodule // tb_ncb_preset_bank
